// ### spa_alarm_top.v
// Purpose: Four setpoint alarm channels behind an APB slave
// Assumes: Counter and rate values arrive on i_clk, signed 32-bit
// Notes: Outputs 5..8 are host-driven bits only
// How it works
// - All channels re-evaluate on a 1000 Hz tick from the clock.
// - Writing zero to a channel's state bit turns its output off unless reverse is set.
// - Source none disables comparison; host bit drives the output.
// - Host drives outputs five to eight directly.
// - Channel n drives pin n; state readable at state bit n.
// - Source is counter A/B/C or rate A/B/C display value.
// - Counter latch turns on at equality and holds until reset.
// - Counter timeout turns on at equality, off after time-out.
// - Counter boundary high-acting: on while count at or above limit.
// - Counter boundary low-acting: on while count at or below limit.
// - Rate latch turns on at or beyond limit and holds until reset.
// - Rate latch re-activates after reset if still beyond limit.
// - Rate timeout cycles the output while beyond limit.
// - One-shot gives a single time-out pulse, no cycling.
// - Rate boundary turns on beyond limit, releases by hysteresis.
// - Release threshold is limit minus or plus hysteresis.
// - Cycling is on for time-out, off for on-delay.
// - Reverse logic inverts the alarm on the output.
//
// Implementation choices: the placing of the registers and the APB register port.
`include "spa_regs.vh"
module spa_alarm_top
#(
	parameter NCH = 4,
	parameter TICK_DIV = `SPA_CLK_HZ / `SPA_TICK_HZ
)
(
	// Clock and reset
	input wire i_clk,
	input wire i_srst,
	// APB slave
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	output wire o_pready,
	output wire o_pslverr,
	output reg [31:0] o_prdata,
	// Measured values
	input wire [31:0] i_cnt_a,
	input wire [31:0] i_cnt_b,
	input wire [31:0] i_cnt_c,
	input wire [31:0] i_rate_a,
	input wire [31:0] i_rate_b,
	input wire [31:0] i_rate_c,
	// Discrete outputs
	output wire [3:0] o_alarm_out_pin,
	output wire [3:0] o_host_out_bit
);
	reg [17:0] div_q;
	reg tick_q;
	reg [3:0] host1_q;
	reg [3:0] host5_q;
	reg [7:0] cfg_q [0:NCH-1];
	reg [31:0] lim_q [0:NCH-1];
	reg [31:0] hys_q [0:NCH-1];
	reg [31:0] tout_q [0:NCH-1];
	reg [31:0] dly_q [0:NCH-1];
	reg [3:0] pin_q;
	wire [3:0] alarm;
	wire [3:0] clr;
	wire wr = i_psel && i_penable && i_pwrite;
	wire [11:0] ofs = i_paddr & 12'hff0;
	wire [1:0] idx = i_paddr[3:2];
	wire in_map = (i_paddr[1:0] == 2'h0) && (i_paddr < 12'h060) &&
		(ofs != `SPA_OUT_STATE || idx == 2'h0);
	// Single-cycle access phase keeps the master's wait simple
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel && i_penable && !in_map;
	assign o_alarm_out_pin = pin_q;
	assign o_host_out_bit = host5_q;
	// Tick divider
	always @(posedge i_clk)
	begin
		if (i_srst)
		begin
			div_q <= 18'h0;
			tick_q <= 1'b0;
		end
		else if (div_q == TICK_DIV - 1)
		begin
			div_q <= 18'h0;
			tick_q <= 1'b1;
		end
		else
		begin
			div_q <= div_q + 18'h1;
			tick_q <= 1'b0;
		end
	end
	// Register writes
	integer k;
	always @(posedge i_clk)
	begin
		if (i_srst)
		begin
			host1_q <= 4'h0;
			host5_q <= 4'h0;
			for (k = 0; k < NCH; k = k + 1)
			begin
				cfg_q[k] <= 8'h0;
				lim_q[k] <= 32'h0;
				hys_q[k] <= 32'h0;
				tout_q[k] <= 32'h0;
				dly_q[k] <= 32'h0;
			end
		end
		else if (wr && in_map)
		begin
			case (ofs)
			`SPA_OUT_STATE:
			begin
				host1_q <= i_pwdata[3:0];
				host5_q <= i_pwdata[7:4];
			end
			`SPA_CFG0:
				cfg_q[idx] <= i_pwdata[7:0];
			`SPA_LIMIT0:
				lim_q[idx] <= i_pwdata;
			`SPA_HYST0:
				hys_q[idx] <= i_pwdata;
			`SPA_TOUT0:
				tout_q[idx] <= i_pwdata;
			`SPA_DLY0:
				dly_q[idx] <= i_pwdata;
			default:
				host1_q <= host1_q;
			endcase
		end
	end
	// Read mux
	always @*
	begin
		o_prdata = 32'h0;
		case (ofs)
		`SPA_OUT_STATE:
			o_prdata = {24'h0, host5_q, pin_q};
		`SPA_CFG0:
			o_prdata = {24'h0, cfg_q[idx]};
		`SPA_LIMIT0:
			o_prdata = lim_q[idx];
		`SPA_HYST0:
			o_prdata = hys_q[idx];
		`SPA_TOUT0:
			o_prdata = tout_q[idx];
		`SPA_DLY0:
			o_prdata = dly_q[idx];
		default:
			o_prdata = 32'h0;
		endcase
	end
	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1)
		begin : ch
			reg [31:0] val;
			always @*
			begin
				case (cfg_q[g][`SPA_F_SRC])
				`SPA_SRC_CNTA: val = i_cnt_a;
				`SPA_SRC_CNTB: val = i_cnt_b;
				`SPA_SRC_CNTC: val = i_cnt_c;
				`SPA_SRC_RATEA: val = i_rate_a;
				`SPA_SRC_RATEB: val = i_rate_b;
				`SPA_SRC_RATEC: val = i_rate_c;
				default: val = 32'h0;
				endcase
			end
			// Zero written to a state bit clears that alarm
			assign clr[g] = wr && ofs == `SPA_OUT_STATE && !i_pwdata[g];
			spa_channel u_ch
			(
				.i_clk(i_clk),
				.i_srst(i_srst),
				.i_tick(tick_q),
				.i_cfg(cfg_q[g]),
				.i_limit(lim_q[g]),
				.i_hyst(hys_q[g]),
				.i_tout(tout_q[g]),
				.i_dly(dly_q[g]),
				.i_value(val),
				.i_clr(clr[g]),
				.o_alarm(alarm[g])
			);
			always @(posedge i_clk)
			begin
				if (i_srst)
					pin_q[g] <= 1'b0;
				else if (cfg_q[g][`SPA_F_SRC] == `SPA_SRC_NONE)
					pin_q[g] <= host1_q[g];
				else
					pin_q[g] <= alarm[g] ^ cfg_q[g][`SPA_F_REV];
			end
		end
	endgenerate
endmodule

// ### spa_regs.vh
`ifndef SPA_REGS_VH
`define SPA_REGS_VH
// Register byte offsets (one aligned 32-bit word each)
`define SPA_OUT_STATE 12'h000
`define SPA_CFG0 12'h010
`define SPA_LIMIT0 12'h020
`define SPA_HYST0 12'h030
`define SPA_TOUT0 12'h040
`define SPA_DLY0 12'h050
`define SPA_CH_STRIDE 12'h004
// Channel config fields
`define SPA_F_SRC 2:0
`define SPA_F_ACT 4:3
`define SPA_F_LOW 5
`define SPA_F_REV 6
`define SPA_F_ONE 7
// Source codes
`define SPA_SRC_NONE 3'h0
`define SPA_SRC_CNTA 3'h1
`define SPA_SRC_CNTB 3'h2
`define SPA_SRC_CNTC 3'h3
`define SPA_SRC_RATEA 3'h4
`define SPA_SRC_RATEB 3'h5
`define SPA_SRC_RATEC 3'h6
// Action codes
`define SPA_ACT_LATCH 2'h0
`define SPA_ACT_TOUT 2'h1
`define SPA_ACT_BOUND 2'h2
// Timing
`define SPA_CLK_HZ 250000000
`define SPA_TICK_HZ 1000
`endif

// ### spa_channel.v
// Purpose: One setpoint channel, evaluated on each update tick
// Assumes: Tick is a one-cycle pulse; sources are signed 32-bit
// Notes: Durations count ticks, so they are in milliseconds
`include "spa_regs.vh"
module spa_channel
(
	// Clock and reset
	input wire i_clk,
	input wire i_srst,
	input wire i_tick,
	// Configuration
	input wire [7:0] i_cfg,
	input wire [31:0] i_limit,
	input wire [31:0] i_hyst,
	input wire [31:0] i_tout,
	input wire [31:0] i_dly,
	input wire [31:0] i_value,
	// Host clear of the alarm
	input wire i_clr,
	// Alarm state
	output wire o_alarm
);
	localparam ST_OFF = 2'h0;
	localparam ST_ON = 2'h1;
	localparam ST_GAP = 2'h2;
	localparam ST_DONE = 2'h3;
	wire [2:0] src = i_cfg[`SPA_F_SRC];
	wire [1:0] act = i_cfg[`SPA_F_ACT];
	wire low = i_cfg[`SPA_F_LOW];
	wire one = i_cfg[`SPA_F_ONE];
	wire is_rate = src[2];
	wire signed [31:0] v = i_value;
	wire signed [31:0] lim = i_limit;
	wire signed [32:0] rel_hi = {lim[31], lim} - {i_hyst[31], i_hyst};
	wire signed [32:0] rel_lo = {lim[31], lim} + {i_hyst[31], i_hyst};
	wire signed [32:0] v33 = {v[31], v};
	wire eq = v == lim;
	wire beyond = low ? (v <= lim) : (v >= lim);
	wire released = low ? (v33 > rel_lo) : (v33 < rel_hi);
	reg [1:0] st_q;
	reg [31:0] cnt_q;
	reg alarm_q;
	assign o_alarm = alarm_q;
	always @(posedge i_clk)
	begin
		if (i_srst)
		begin
			st_q <= ST_OFF;
			cnt_q <= 32'h0;
			alarm_q <= 1'b0;
		end
		else if (i_clr)
		begin
			// Rate latch re-arms on the next tick if still beyond
			st_q <= ST_OFF;
			cnt_q <= 32'h0;
			alarm_q <= 1'b0;
		end
		else if (i_tick && src != `SPA_SRC_NONE)
		begin
			case (act)
			`SPA_ACT_LATCH:
			begin
				if (is_rate ? (eq || beyond) : eq)
					alarm_q <= 1'b1;
			end
			`SPA_ACT_TOUT:
			begin
				if (!is_rate)
				begin
					if (alarm_q)
					begin
						if (cnt_q + 32'h1 >= i_tout)
							alarm_q <= 1'b0;
						cnt_q <= cnt_q + 32'h1;
					end
					else if (eq)
					begin
						alarm_q <= 1'b1;
						cnt_q <= 32'h0;
					end
				end
				else
				begin
					case (st_q)
					ST_OFF:
					begin
						cnt_q <= 32'h0;
						if (beyond)
						begin
							st_q <= ST_ON;
							alarm_q <= 1'b1;
						end
					end
					ST_ON:
					begin
						cnt_q <= cnt_q + 32'h1;
						if (cnt_q + 32'h1 >= i_tout)
						begin
							cnt_q <= 32'h0;
							alarm_q <= 1'b0;
							st_q <= one ? ST_DONE : ST_GAP;
						end
					end
					ST_GAP:
					begin
						cnt_q <= cnt_q + 32'h1;
						if (!beyond)
							st_q <= ST_OFF;
						else if (cnt_q + 32'h1 >= i_dly)
						begin
							cnt_q <= 32'h0;
							alarm_q <= 1'b1;
							st_q <= ST_ON;
						end
					end
					default:
					begin
						// One pulse per excursion
						if (!beyond)
							st_q <= ST_OFF;
					end
					endcase
				end
			end
			`SPA_ACT_BOUND:
			begin
				if (!is_rate)
					alarm_q <= beyond;
				else if (beyond)
					alarm_q <= 1'b1;
				else if (released)
					alarm_q <= 1'b0;
			end
			default:
				alarm_q <= 1'b0;
			endcase
		end
	end
endmodule

// ### spa_meas_model.sv
// Purpose: Counter and rate values that face the alarm block
// Assumes: The bench loads one value at a time
// Notes: Values move only on i_clk, like the real measuring logic
module spa_meas_model
(
	// Load port
	input wire i_clk,
	input wire i_ld,
	input wire [2:0] i_sel,
	input wire [31:0] i_val,
	// Counts A-C then rates A-C
	output logic [31:0] o_val [0:5]
);
	timeunit 1ns;
	timeprecision 1ns;
	initial o_val = '{default: 32'h0};
	always @(posedge i_clk)
		if (i_ld)
			o_val[i_sel] <= i_val;
endmodule

// ### spa_alarm_chk_sva.sv
// Purpose: Port checks of the setpoint alarm block
// Assumes: Channel 1 config and limit are shadowed from APB writes
// Notes: Waits span three ticks since the tick phase is hidden
`include "spa_regs.vh"
module spa_alarm_chk
#(
	parameter NCH = 4,
	parameter TICK_DIV = 20
)
(
	// Clock and reset
	input wire i_clk,
	input wire i_srst,
	// APB
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	input wire o_pslverr,
	input wire [31:0] o_prdata,
	// Values and outputs
	input wire [31:0] i_cnt_a,
	input wire [3:0] o_alarm_out_pin,
	input wire [3:0] o_host_out_bit
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int W = 3 * TICK_DIV;
	logic [7:0] cfg_q;
	logic [31:0] lim_q;
	wire acc = i_psel && i_penable;
	wire wr0 = acc && i_pwrite && i_paddr == `SPA_OUT_STATE;
	wire ge = $signed(i_cnt_a) >= $signed(lim_q);
	wire le = $signed(i_cnt_a) <= $signed(lim_q);
	always @(posedge i_clk)
		if (i_srst)
		begin
			cfg_q <= 8'h0;
			lim_q <= 32'h0;
		end
		else if (acc && i_pwrite)
		begin
			if (i_paddr == `SPA_CFG0)
				cfg_q <= i_pwdata[7:0];
			if (i_paddr == `SPA_LIMIT0)
				lim_q <= i_pwdata;
		end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	property p_rst;
		$fell(i_srst) |-> o_alarm_out_pin == 4'h0 && o_host_out_bit == 4'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs live after reset");
	property p_hst;
		wr0 |=> o_host_out_bit == $past(i_pwdata[7:4]);
	endproperty
	a_hst: assert property (p_hst) else $error("host bits stale");
	property p_rd;
		acc && !i_pwrite && i_paddr == `SPA_OUT_STATE |->
			o_prdata[7:0] == {o_host_out_bit, o_alarm_out_pin};
	endproperty
	a_rd: assert property (p_rd) else $error("state readback wrong");
	property p_err;
		acc && i_paddr > 12'h05c |-> o_pslverr;
	endproperty
	a_err: assert property (p_err) else $error("unmapped not flagged");
	property p_clr;
		wr0 && !i_pwdata[0] && cfg_q[2:0] != 3'h0 && !cfg_q[6] |=> ##1 !o_alarm_out_pin[0];
	endproperty
	a_clr: assert property (p_clr) else $error("zero write kept alarm");
	property p_none;
		wr0 && i_pwdata[0] && cfg_q == 8'h0 |-> ##[1:W] o_alarm_out_pin[0];
	endproperty
	a_none: assert property (p_none) else $error("host value not on pin");
	property p_bhi;
		cfg_q == 8'h11 && $changed(ge) |-> ##[1:W] o_alarm_out_pin[0] == ge;
	endproperty
	a_bhi: assert property (p_bhi) else $error("high boundary wrong");
	property p_blo;
		cfg_q == 8'h31 && $changed(le) |-> ##[1:W] o_alarm_out_pin[0] == le;
	endproperty
	a_blo: assert property (p_blo) else $error("low boundary wrong");
	c_on: cover property ($rose(o_alarm_out_pin[0]));
	c_clr: cover property (wr0 && !i_pwdata[0]);
	c_err: cover property (acc && o_pslverr);
endmodule

// ### spa_alarm_top_test.sv
// Purpose: Self-checking bench for the setpoint alarm block
// Assumes: Tick every 20 clocks, so updates come quickly
// Notes: Channel 1 carries the mode tests; the rest stay unassigned
`include "spa_regs.vh"
module spa_alarm_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TD = 20;
	logic i_clk = 0, i_srst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, ld = 0, rdy, err;
	logic [11:0] i_paddr = 0;
	logic [31:0] i_pwdata = 0, o_prdata, r, lv = 0;
	logic [2:0] ls = 0;
	logic [3:0] o_alarm_out_pin, o_host_out_bit;
	logic o_pready, o_pslverr;
	logic [31:0] mv [0:5];
	int num_errors = 0, n_tests = 0, c;
	// Config, limit, source slot, value, expected pin
	logic [75:0] rows [0:8] = '{
		{8'h11, 32'd5, 3'd0, 32'd5, 1'b1}, {8'h11, 32'd5, 3'd0, 32'd4, 1'b0},
		{8'h11, 32'd5, 3'd0, 32'hffffffff, 1'b0}, {8'h31, 32'd5, 3'd0, 32'hffffffff, 1'b1},
		{8'h31, 32'd5, 3'd0, 32'd6, 1'b0}, {8'h71, 32'd5, 3'd0, 32'd6, 1'b1},
		{8'h14, 32'd10, 3'd3, 32'd10, 1'b1}, {8'h14, 32'd10, 3'd3, 32'd8, 1'b1},
		{8'h14, 32'd10, 3'd3, 32'd6, 1'b0}};
	spa_alarm_top #(.TICK_DIV(TD)) dut (.*, .i_cnt_a(mv[0]), .i_cnt_b(mv[1]), .i_cnt_c(mv[2]),
		.i_rate_a(mv[3]), .i_rate_b(mv[4]), .i_rate_c(mv[5]));
	spa_meas_model u_meas (.i_clk(i_clk), .i_ld(ld), .i_sel(ls), .i_val(lv), .o_val(mv));
	initial
		forever #2 i_clk = ~i_clk;
	task automatic bus(input logic [11:0] a, input logic [31:0] d, input logic w);
		i_psel <= 1'b1;
		i_paddr <= a;
		i_pwdata <= d;
		i_pwrite <= w;
		@(posedge i_clk);
		i_penable <= 1'b1;
		rdy = 1'b0;
		// Data is taken at the rising edge that sees pready high, not before
		for (int k = 0; k < 50 && rdy !== 1'b1; k++)
		begin
			@(posedge i_clk);
			rdy = o_pready;
			r = o_prdata;
			err = o_pslverr;
		end
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		if (rdy !== 1'b1)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t no pready", $time);
		end
		@(posedge i_clk);
	endtask
	task put(input logic [2:0] s, input logic [31:0] v);
		ld <= 1'b1;
		ls <= s;
		lv <= v;
		@(posedge i_clk);
		ld <= 1'b0;
	endtask
	task tk(input int n);
		repeat (n * TD + 3) @(posedge i_clk);
	endtask
	task cnt_on(input int n);
		c = 0;
		repeat (n)
		begin
			@(negedge i_clk);
			c += o_alarm_out_pin[0];
		end
		@(posedge i_clk);
	endtask
	task chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e)
		begin
			num_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task end_of_test;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(posedge i_clk);
		i_srst <= 1'b0;
		@(posedge i_clk);
		bus(`SPA_HYST0, 32'd3, 1'b1);
		foreach (rows[i])
		begin
			bus(`SPA_CFG0, {24'h0, rows[i][75:68]}, 1'b1);
			bus(`SPA_LIMIT0, rows[i][67:36], 1'b1);
			put(rows[i][35:33], rows[i][32:1]);
			tk(1);
			bus(`SPA_OUT_STATE, 32'h0, 1'b0);
			chk(8'(r[0]), 8'(rows[i][0]));
		end
		$display("table done");
		bus(`SPA_CFG0, 32'h01, 1'b1);
		put(3'd0, 32'd10);
		tk(1);
		put(3'd0, 32'd11);
		tk(1);
		bus(`SPA_OUT_STATE, 32'h0, 1'b0);
		chk(8'(r[0]), 8'h1);
		bus(`SPA_OUT_STATE, 32'h0, 1'b1);
		tk(1);
		bus(`SPA_OUT_STATE, 32'h0, 1'b0);
		chk(8'(r[0]), 8'h0);
		$display("count latch done");
		bus(`SPA_TOUT0, 32'd2, 1'b1);
		bus(`SPA_DLY0, 32'd2, 1'b1);
		bus(`SPA_CFG0, 32'h09, 1'b1);
		put(3'd0, 32'd10);
		tk(1);
		bus(`SPA_OUT_STATE, 32'h0, 1'b0);
		chk(8'(r[0]), 8'h1);
		put(3'd0, 32'd11);
		tk(3);
		bus(`SPA_OUT_STATE, 32'h0, 1'b0);
		chk(8'(r[0]), 8'h0);
		$display("count timeout done");
		bus(`SPA_CFG0, 32'h04, 1'b1);
		put(3'd3, 32'd10);
		tk(1);
		bus(`SPA_OUT_STATE, 32'h0, 1'b0);
		chk(8'(r[0]), 8'h1);
		bus(`SPA_OUT_STATE, 32'h0, 1'b1);
		tk(1);
		bus(`SPA_OUT_STATE, 32'h0, 1'b0);
		chk(8'(r[0]), 8'h1);
		$display("rate latch done");
		bus(`SPA_CFG0, 32'h0c, 1'b1);
		tk(2);
		cnt_on(160);
		chk(8'(c), 8'd80);
		put(3'd3, 32'd5);
		tk(3);
		bus(`SPA_CFG0, 32'h8c, 1'b1);
		put(3'd3, 32'd12);
		cnt_on(200);
		chk(8'(c), 8'd40);
		$display("rate timeout done");
		bus(`SPA_CFG0, 32'h0, 1'b1);
		bus(`SPA_OUT_STATE, 32'hf1, 1'b1);
		tk(1);
		bus(`SPA_OUT_STATE, 32'h0, 1'b0);
		chk(r[7:0], 8'hf1);
		bus(12'h100, 32'h0, 1'b0);
		chk(8'(err), 8'h1);
		i_srst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_srst <= 1'b0;
		@(posedge i_clk);
		bus(`SPA_OUT_STATE, 32'h0, 1'b0);
		chk(r[7:0], 8'h0);
		$display("host and reset done");
		end_of_test;
	end
	// Whole run is near 1100 clocks
	initial
	begin
		repeat (5000) @(posedge i_clk);
		num_errors++;
		end_of_test;
	end
endmodule
bind spa_alarm_top spa_alarm_chk #(.NCH(NCH), .TICK_DIV(TICK_DIV)) u_chk (.*);
